// file: hdl/bridge_memory_window_decoder.sv
// memory window decode for the bridge, with an APB register slave
// assumes one clock domain; requests are one-cycle strobes from core logic
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "mem_window_cfg.svh"
module bridge_memory_window_decoder
  import mem_window_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // downstream request from the upstream link
  input wire logic dnValid,
  input wire logic [63:0] dnAddr,
  input wire logic dnLongAddr,
  input wire logic dnRead,
  input wire logic [9:0] dnLenDw,
  // downstream decision
  output logic dnDone,
  output mem_window_pkg::dn_route_t dnRoute,
  output logic [9:0] dnFetchDw,
  // request seen on the secondary bus
  input wire logic upValid,
  input wire logic [63:0] upAddr,
  input wire logic [3:0] upCmd,
  // upstream decision
  output logic upDone,
  output mem_window_pkg::up_route_t upRoute,
  output logic upPrefetch
);
  import mem_window_pkg::*;

  logic [31:0] npWin_r;
  logic [31:0] pfBaseLimLo_r;
  logic [31:0] pfBaseHi_r;
  logic [31:0] pfLimHi_r;
  logic memSpaceEnable_r;
  logic busMasterEnable_r;
  logic vgaEnable_r;
  logic [15:0] dnCount_r;
  logic [15:0] upCount_r;
  logic npHitDn;
  logic npHitUp;
  logic pfEn;
  logic pfHitDn;
  logic pfHitUp;
  logic [63:0] dnAddrEff;
  logic dnVga;
  logic upVga;
  logic dnClaim;
  logic upBlock;
  logic isRead;
  logic wrAccess;
  logic rdAccess;
  logic mapped;
  dn_route_t dnRoute_nxt;
  up_route_t upRoute_nxt;
  logic upPrefetch_nxt;

  // apb handshake: zero wait states
  assign wrAccess = psel && penable && pwrite;
  assign rdAccess = psel && !penable && !pwrite;
  always_comb
  begin
    unique case (paddr)
      `MW_ADR_NP_BASE, `MW_ADR_PF_BASE_LO, `MW_ADR_PF_BASE_HI,
      `MW_ADR_PF_LIM_HI, `MW_ADR_CTRL, `MW_ADR_STAT:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // window registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      npWin_r <= 32'h00000000;
      pfBaseLimLo_r <= 32'h00000000;
      pfBaseHi_r <= 32'h00000000;
      pfLimHi_r <= 32'h00000000;
    end
    else if (wrAccess)
    begin
      if (paddr == `MW_ADR_NP_BASE)
        npWin_r <= pwdata;
      if (paddr == `MW_ADR_PF_BASE_LO)
        pfBaseLimLo_r <= pwdata;
      if (paddr == `MW_ADR_PF_BASE_HI)
        pfBaseHi_r <= pwdata;
      if (paddr == `MW_ADR_PF_LIM_HI)
        pfLimHi_r <= pwdata;
    end
  end

  // control bits
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      memSpaceEnable_r <= 1'b0;
      busMasterEnable_r <= 1'b0;
      vgaEnable_r <= 1'b0;
    end
    else if (wrAccess && paddr == `MW_ADR_CTRL)
    begin
      memSpaceEnable_r <= pwdata[`MW_BIT_MSE];
      busMasterEnable_r <= pwdata[`MW_BIT_BME];
      vgaEnable_r <= pwdata[`MW_BIT_VGA];
    end
  end

  // read data captured in setup, valid in access phase
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (rdAccess)
    begin
      unique case (paddr)
        `MW_ADR_NP_BASE: prdata <= npWin_r;
        `MW_ADR_PF_BASE_LO: prdata <= pfBaseLimLo_r;
        `MW_ADR_PF_BASE_HI: prdata <= pfBaseHi_r;
        `MW_ADR_PF_LIM_HI: prdata <= pfLimHi_r;
        `MW_ADR_CTRL: prdata <= {29'h00000000, vgaEnable_r,
          busMasterEnable_r, memSpaceEnable_r};
        `MW_ADR_STAT: prdata <= {dnCount_r, upCount_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // short address format carries only the low 32 bits
  assign dnAddrEff = dnLongAddr ? dnAddr :
    {`MW_HI_ZERO, dnAddr[31:0]};

  // non-prefetchable window lies below 4 GB
  window_range_check #(
    .UNIT_W(12)
  ) npDnCheck (
    .baseUnit(npWin_r[15:4]),
    .limitUnit(npWin_r[31:20]),
    .addr(dnAddrEff),
    .enabled(),
    .hit(npHitDn)
  );
  window_range_check #(
    .UNIT_W(12)
  ) npUpCheck (
    .baseUnit(npWin_r[15:4]),
    .limitUnit(npWin_r[31:20]),
    .addr(upAddr),
    .enabled(),
    .hit(npHitUp)
  );

  // 64-bit prefetchable compare, may straddle 4 GB
  window_range_check #(
    .UNIT_W(44)
  ) pfDnCheck (
    .baseUnit({pfBaseHi_r, pfBaseLimLo_r[15:4]}),
    .limitUnit({pfLimHi_r, pfBaseLimLo_r[31:20]}),
    .addr(dnAddrEff),
    .enabled(pfEn),
    .hit(pfHitDn)
  );
  window_range_check #(
    .UNIT_W(44)
  ) pfUpCheck (
    .baseUnit({pfBaseHi_r, pfBaseLimLo_r[15:4]}),
    .limitUnit({pfLimHi_r, pfBaseLimLo_r[31:20]}),
    .addr(upAddr),
    .enabled(),
    .hit(pfHitUp)
  );

  // legacy frame buffer range
  assign dnVga = vgaEnable_r && dnAddrEff >= `MW_VGA_LO &&
    dnAddrEff <= `MW_VGA_HI;
  assign upVga = vgaEnable_r && upAddr >= `MW_VGA_LO &&
    upAddr <= `MW_VGA_HI;

  assign dnClaim = npHitDn || pfHitDn || dnVga;
  // with memory enable clear nothing is blocked upstream
  assign upBlock = memSpaceEnable_r &&
    (npHitUp || pfHitUp || upVga);

  always_comb
  begin
    if (!memSpaceEnable_r)
      dnRoute_nxt = DN_UR;
    else if (dnClaim)
      dnRoute_nxt = DN_FWD;
    else
      dnRoute_nxt = DN_NONE;
  end

  assign isRead = (upCmd == `MW_CMD_MRD) || (upCmd == `MW_CMD_MRL) ||
    (upCmd == `MW_CMD_MRM);

  always_comb
  begin
    upPrefetch_nxt = 1'b0;
    if (!busMasterEnable_r)
      upRoute_nxt = UP_IGNORE;
    else if (upBlock)
      upRoute_nxt = UP_NONE;
    else
    begin
      upRoute_nxt = UP_FWD;
      if (pfEn && pfHitUp)
        upPrefetch_nxt = isRead;
      else
        upPrefetch_nxt = (upCmd == `MW_CMD_MRL) ||
          (upCmd == `MW_CMD_MRM);
    end
  end

  // downstream decision register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dnDone <= 1'b0;
      dnRoute <= DN_NONE;
      dnFetchDw <= 10'h000;
    end
    else
    begin
      dnDone <= dnValid;
      if (dnValid)
      begin
        dnRoute <= dnRoute_nxt;
        // reads fetch exactly the request length, writes fetch nothing
        dnFetchDw <= dnRead ? dnLenDw : 10'h000;
      end
    end
  end

  // upstream decision register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      upDone <= 1'b0;
      upRoute <= UP_NONE;
      upPrefetch <= 1'b0;
    end
    else
    begin
      upDone <= upValid;
      if (upValid)
      begin
        upRoute <= upRoute_nxt;
        upPrefetch <= upPrefetch_nxt;
      end
    end
  end

  // forwarded counts for status
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dnCount_r <= 16'h0000;
      upCount_r <= 16'h0000;
    end
    else
    begin
      if (dnValid && dnRoute_nxt == DN_FWD)
        dnCount_r <= dnCount_r + 16'h0001;
      if (upValid && upRoute_nxt == UP_FWD)
        upCount_r <= upCount_r + 16'h0001;
    end
  end
endmodule

// file: hdl/mem_window_cfg.svh
// constants for the bridge memory window decoder
// assumes inclusion by the design files and the bench
`ifndef MEM_WINDOW_CFG_SVH
`define MEM_WINDOW_CFG_SVH
`define MW_GRAN_BITS 20
`define MW_LOW_ONES 20'hFFFFF
`define MW_LOW_ZERO 20'h00000
`define MW_VGA_LO 64'h00000000000A0000
`define MW_VGA_HI 64'h00000000000BFFFF
`define MW_HI_ZERO 32'h00000000
`define MW_CMD_MRD 4'h6
`define MW_CMD_MRL 4'hE
`define MW_CMD_MRM 4'hC
`define MW_ADR_NP_BASE 12'h000
`define MW_ADR_PF_BASE_LO 12'h004
`define MW_ADR_PF_BASE_HI 12'h008
`define MW_ADR_PF_LIM_HI 12'h00C
`define MW_ADR_CTRL 12'h010
`define MW_ADR_STAT 12'h014
`define MW_BIT_MSE 0
`define MW_BIT_BME 1
`define MW_BIT_VGA 2
`endif

// file: hdl/mem_window_pkg.sv
// types for the bridge memory window decoder
// assumes mem_window_cfg.svh is reachable by include path
package mem_window_pkg;
  typedef enum logic [2:0] {
    DN_NONE = 3'b001,
    DN_FWD = 3'b010,
    DN_UR = 3'b100
  } dn_route_t;
  typedef enum logic [2:0] {
    UP_NONE = 3'b001,
    UP_FWD = 3'b010,
    UP_IGNORE = 3'b100
  } up_route_t;
endpackage

// file: hdl/window_range_check.sv
// one base/limit range compare at 1 MB granularity
// assumes base and limit given as 1 MB unit numbers
`timescale 1ns/10ps
`include "mem_window_cfg.svh"
module window_range_check #(
  parameter int UNIT_W = 44
) (
  // window
  input wire logic [UNIT_W-1:0] baseUnit,
  input wire logic [UNIT_W-1:0] limitUnit,
  // address
  input wire logic [63:0] addr,
  // result
  output logic enabled,
  output logic hit
);
  logic [63:0] baseFull;
  logic [63:0] limitFull;
  // base low bits zero, limit low bits ones
  assign baseFull = 64'({baseUnit, `MW_LOW_ZERO});
  assign limitFull = 64'({limitUnit, `MW_LOW_ONES});
  assign enabled = (baseFull <= limitFull);
  assign hit = enabled && (addr >= baseFull) && (addr <= limitFull);
endmodule

// file: verification/decoder_chk.sv
// checker for the memory window decoder ports
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/10ps
module decoder_chk
  import mem_window_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // downstream
  input wire logic dnValid,
  input wire logic dnRead,
  input wire logic [9:0] dnLenDw,
  input wire logic dnDone,
  input wire logic [9:0] dnFetchDw,
  input wire mem_window_pkg::dn_route_t dnRoute,
  // upstream
  input wire logic upValid,
  input wire logic upDone,
  input wire mem_window_pkg::up_route_t upRoute
);
  import mem_window_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_dn_answer: assert property (dnValid |=> dnDone)
    else $error("downstream answer missing");
  chk_dn_cause: assert property (dnDone |-> $past(dnValid))
    else $error("downstream answer without request");
  chk_up_answer: assert property (upValid |=> upDone)
    else $error("upstream answer missing");
  chk_up_cause: assert property (upDone |-> $past(upValid))
    else $error("upstream answer without request");
  chk_fetch_read: assert property
    (dnValid && dnRead |=> dnFetchDw == $past(dnLenDw))
    else $error("fetch length differs from request");
  chk_fetch_write: assert property
    (dnValid && !dnRead |=> dnFetchDw == 10'h000)
    else $error("fetch length on write");
  chk_apb_wait: assert property (psel && !penable |=> pready)
    else $error("apb answer late");
  chk_ready_place: assert property (pready |-> psel && penable)
    else $error("apb ready outside access");
  chk_dn_hold: assert property (!dnValid |=> $stable(dnRoute))
    else $error("downstream route moved");
  chk_up_hold: assert property (!upValid |=> $stable(upRoute))
    else $error("upstream route moved");
  cover property (dnDone && dnRoute == DN_UR);
  cover property (upDone && upRoute == UP_IGNORE);
  cover property (pready && pslverr);
endmodule
bind bridge_memory_window_decoder decoder_chk decoder_chk_inst (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .dnValid(dnValid),
  .dnRead(dnRead), .dnLenDw(dnLenDw), .dnDone(dnDone),
  .dnFetchDw(dnFetchDw), .dnRoute(dnRoute), .upValid(upValid),
  .upDone(upDone), .upRoute(upRoute));

// file: verification/link_agent.sv
// request source for the link side and the secondary bus
// assumes tasks are called from one process at a time
`timescale 1ns/10ps
module link_agent
(
  // clock
  input wire logic clk,
  // downstream request
  output logic dnValid,
  output logic [63:0] dnAddr,
  output logic dnLongAddr,
  output logic dnRead,
  output logic [9:0] dnLenDw,
  // secondary bus request
  output logic upValid,
  output logic [63:0] upAddr,
  output logic [3:0] upCmd
);
  initial
  begin
    {dnValid, dnAddr, dnLongAddr, dnRead, dnLenDw} = '0;
    {upValid, upAddr, upCmd} = '0;
  end
  // one-cycle strobe, fields except dnLongAddr inverted once released
  task automatic dnReq(input logic l, input logic [63:0] a,
    input logic r);
    @(posedge clk);
    dnValid <= 1'b1;
    dnAddr <= a;
    dnLongAddr <= l;
    dnRead <= r;
    dnLenDw <= 10'h005;
    @(posedge clk);
    dnValid <= 1'b0;
    dnAddr <= ~a;
    dnRead <= ~r;
    dnLenDw <= 10'h3FA;
  endtask
  task automatic upReq(input logic [63:0] a, input logic [3:0] c);
    @(posedge clk);
    upValid <= 1'b1;
    upAddr <= a;
    upCmd <= c;
    @(posedge clk);
    upValid <= 1'b0;
    upAddr <= ~a;
    upCmd <= ~c;
  endtask
endmodule

// file: verification/bridge_memory_window_decoder_tb_top.sv
// bench: register setup, table of decode cases, hand cases
// assumes the config header is on the include path
`timescale 1ns/10ps
`include "mem_window_cfg.svh"
module bridge_memory_window_decoder_tb_top;
  import mem_window_pkg::*;
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  failCount++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
  typedef struct packed {logic l; logic [63:0] a; logic r;
    dn_route_t e;} dn_row_t;
  typedef struct packed {logic [63:0] a; logic [3:0] c;
    up_route_t e; logic p;} up_row_t;
  localparam dn_row_t DN [7] = '{
    '{0, 64'h10000000, 1, DN_FWD}, '{0, 64'h1FFFFFFC, 0, DN_FWD},
    '{0, 64'h0FFFFFFC, 1, DN_NONE}, '{0, 64'h20000000, 1, DN_FWD},
    '{0, 64'h120000000, 0, DN_FWD}, '{1, 64'h100000000, 1, DN_FWD},
    '{1, 64'h200000000, 1, DN_NONE}};
  localparam up_row_t UP [8] = '{
    '{64'h10000000, `MW_CMD_MRL, UP_NONE, 0},
    '{64'h1FFFFFFC, `MW_CMD_MRD, UP_NONE, 0},
    '{64'h20000000, `MW_CMD_MRD, UP_NONE, 0},
    '{64'h1FFFFFFFC, `MW_CMD_MRM, UP_NONE, 0},
    '{64'h400000000, `MW_CMD_MRD, UP_FWD, 0},
    '{64'h400000000, `MW_CMD_MRL, UP_FWD, 1},
    '{64'h0FFFFFFC, `MW_CMD_MRM, UP_FWD, 1},
    '{64'h400000000, 4'h7, UP_FWD, 0}};
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic dnValid, dnLongAddr, dnRead, dnDone, upValid, upDone;
  logic upPrefetch;
  logic [63:0] dnAddr, upAddr;
  logic [9:0] dnLenDw, dnFetchDw;
  logic [3:0] upCmd;
  dn_route_t dnRoute;
  up_route_t upRoute;
  int failCount = 0;
  int comparisons = 0;
  bridge_memory_window_decoder bridge_memory_window_decoder_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dnValid(dnValid),
    .dnAddr(dnAddr), .dnLongAddr(dnLongAddr), .dnRead(dnRead),
    .dnLenDw(dnLenDw), .dnDone(dnDone), .dnRoute(dnRoute),
    .dnFetchDw(dnFetchDw), .upValid(upValid), .upAddr(upAddr),
    .upCmd(upCmd), .upDone(upDone), .upRoute(upRoute),
    .upPrefetch(upPrefetch));
  link_agent link_agent_inst (.clk(clk), .dnValid(dnValid),
    .dnAddr(dnAddr), .dnLongAddr(dnLongAddr), .dnRead(dnRead),
    .dnLenDw(dnLenDw), .upValid(upValid), .upAddr(upAddr),
    .upCmd(upCmd));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] e, input logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failCount++;
      report_and_stop();
    end
    if (!w)
      `CHK("prdata", e, prdata)
    `CHK("pslverr", er, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dnT(input logic l, input logic [63:0] a, input logic r,
    input dn_route_t e);
    link_agent_inst.dnReq(l, a, r);
    @(negedge clk);
    `CHK("dnDone", 1'b1, dnDone)
    `CHK("dnRoute", e, dnRoute)
    `CHK("dnFetchDw", r ? 10'h005 : 10'h000, dnFetchDw)
  endtask
  task automatic upT(input logic [63:0] a, input logic [3:0] c,
    input up_route_t e, input logic p);
    link_agent_inst.upReq(a, c);
    @(negedge clk);
    `CHK("upDone", 1'b1, upDone)
    `CHK("upRoute", e, upRoute)
    `CHK("upPrefetch", p, upPrefetch)
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge clk);
    `CHK("dnRoute", DN_NONE, dnRoute)
    `CHK("upRoute", UP_NONE, upRoute)
    rst_n <= 1'b1;
    apb(0, `MW_ADR_CTRL, 0, 32'h00000000, 0);
    apb(0, 12'h018, 0, 32'h00000000, 1);
    $display("done reset and unmapped");
    apb(1, `MW_ADR_NP_BASE, 32'h1FF01000, 0, 0);
    apb(1, `MW_ADR_PF_BASE_LO, 32'hFFF02000, 0, 0);
    apb(1, `MW_ADR_PF_LIM_HI, 32'h00000001, 0, 0);
    apb(1, `MW_ADR_CTRL, 32'h00000003, 0, 0);
    apb(0, `MW_ADR_PF_LIM_HI, 0, 32'h00000001, 0);
    foreach (DN[i])
      dnT(DN[i].l, DN[i].a, DN[i].r, DN[i].e);
    foreach (UP[i]) upT(UP[i].a, UP[i].c, UP[i].e, UP[i].p);
    $display("done table");
    apb(1, `MW_ADR_PF_BASE_HI, 32'h00000002, 0, 0);
    dnT(1, 64'h100000000, 1, DN_NONE);
    upT(64'h20000000, `MW_CMD_MRL, UP_FWD, 1);
    apb(1, `MW_ADR_PF_BASE_HI, 32'h00000000, 0, 0);
    $display("done pf disable");
    apb(1, `MW_ADR_CTRL, 32'h00000007, 0, 0);
    dnT(0, 64'h000A0000, 1, DN_FWD);
    dnT(0, 64'h000C0000, 1, DN_NONE);
    upT(64'h000BFFFC, `MW_CMD_MRL, UP_NONE, 0);
    $display("done legacy display");
    apb(1, `MW_ADR_CTRL, 32'h00000002, 0, 0);
    dnT(0, 64'h10000000, 0, DN_UR);
    upT(64'h10000000, `MW_CMD_MRL, UP_FWD, 1);
    upT(64'h20000000, `MW_CMD_MRD, UP_FWD, 1);
    apb(1, `MW_ADR_CTRL, 32'h00000001, 0, 0);
    upT(64'h400000000, `MW_CMD_MRL, UP_IGNORE, 0);
    apb(0, `MW_ADR_STAT, 0, 32'h00060007, 0);
    $display("done enables");
    report_and_stop();
  end
endmodule
